// ### core/fsc_pkg.sv
// Package for the flash status and configuration register block
package fsc_pkg;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] OP_VOL_WRITE_ENABLE_CMD      = 8'h50;
  localparam logic [7:0] OP_STATUS_LO     = 8'h05;
  localparam logic [7:0] OP_STATUS_HI     = 8'h35;
  localparam logic [7:0] OP_CFG_READ_DEF  = 8'h15;
  localparam logic [7:0] OP_CFG_READ_D    = 8'h45;
  localparam logic [7:0] OP_STATUS_WR_LO  = 8'h01;
  localparam logic [7:0] OP_STATUS_WR_HI  = 8'h31;
  localparam logic [7:0] OP_CFG_WRITE     = 8'h11;
  localparam logic [7:0] OP_PAGE_PROG     = 8'h02;
  localparam logic [7:0] OP_DUAL_PROG     = 8'ha2;
  localparam logic [7:0] OP_QUAD_PROG     = 8'h32;
  localparam logic [7:0] OP_PAGE_ERASE    = 8'h81;
  localparam logic [7:0] OP_SECTOR_ERASE  = 8'h20;
  localparam logic [7:0] OP_HALF_BLK_ER   = 8'h52;
  localparam logic [7:0] OP_BLOCK_ERASE   = 8'hd8;
  localparam logic [7:0] OP_CHIP_ERASE_A  = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE_B  = 8'hc7;
  localparam logic [7:0] OP_SECREG_ERASE  = 8'h44;
  localparam logic [7:0] OP_SECREG_PROG   = 8'h42;
  localparam logic [7:0] OP_SUSPEND_A     = 8'h75;
  localparam logic [7:0] OP_SUSPEND_B     = 8'hb0;
  localparam logic [7:0] OP_RESUME_A      = 8'h7a;
  localparam logic [7:0] OP_RESUME_B      = 8'h30;
  localparam logic [7:0] OP_SOFT_RESET    = 8'h99;

  // Status word field positions
  localparam int BIT_BUSY     = 0;
  localparam int BIT_WEL      = 1;
  localparam int BIT_RANGE_LO = 2;
  localparam int BIT_MODE_LO  = 7;
  localparam int BIT_MODE_HI  = 8;
  localparam int BIT_QUAD     = 9;
  localparam int BIT_PSUS     = 10;
  localparam int BIT_LOCK_LO  = 11;
  localparam int BIT_CMP      = 14;
  localparam int BIT_ESUS     = 15;
  // Config byte field positions
  localparam int CFG_PAUSE_RST = 7;
  localparam int CFG_WIDE_PAGE = 4;
  localparam int CFG_LOCK_SCH  = 2;

  localparam logic [15:0] STATUS_RESET   = 16'h0000;
  localparam logic [7:0]  CONFIG_RESET   = 8'h40;
  localparam logic [7:0]  CONFIG_WR_MASK = 8'hf4;
  // Bits never written by status write: suspend flags, latch, busy
  localparam logic [15:0] STATUS_WR_MASK = 16'h7bfc;
  localparam logic [4:0]  RANGE_NONE     = 5'h00;

  // Busy time of a self-timed operation in ns, as a parameter default
  localparam int BUSY_TIME_NS = 2000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int BUSY_CYCLES = (BUSY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    MODE_SOFT, MODE_HW, MODE_POWER_LOCK, MODE_OTP
  } fsc_mode_type;

  // Completed frame handed from link to core domain
  typedef struct packed {
    logic [7:0]  opcode;
    logic [15:0] data;
    logic [4:0]  bitCount;
  } fsc_frame_type;

  // Pin steering outputs
  typedef struct packed {
    logic quadLines;
    logic pinIsReset;
    logic pinIsPause;
    logic widePage;
    logic lockScheme;
    logic [1:0] drive;
  } fsc_pins_type;
endpackage : fsc_pkg

// ### core/fsc_regs.sv
// Status and configuration registers of a serial flash with its serial command front end
//
// How it works
// - Write-disable opcode clears write enable latch
// - Latch cleared on reset and write completions
// - Volatile-write enable arms next status write only
// - 05h reads low byte, 35h high
// - Status reads accepted even while busy
// - Status read: select, opcode, data out
// - Status word bit layout fixed
// - Busy high during program, erase, status write
// - Latch clear rejects writes, programs, erases
// - Range bits writable unless hardware protected, power locked or in OTP mode
// - Chip erase only with no range protection
// - Protect mode pair gates status writes
// - Power cycle releases power lock-down mode
// - Quad enable turns pause/reset pin; protect pin still gates writes
// - Security locks set once, cleared only by reset
// - Complement bit defaults zero, selects region
// - Suspend while busy sets erase flag only, resume clears both
// - Config read 15h (45h with ORDER_OPTION_D) anytime
// - Config byte bit layout fixed
// - Write-enable opcode sets the latch
// - Pause/reset pin select, only without quad
// - Wide page select chooses 1024-byte page
// - Lock scheme select chooses individual locks
`timescale 1ns/10ps
`default_nettype none
module fsc_regs #(
  parameter int BUSY_CYCLES = fsc_pkg::BUSY_CYCLES,
  parameter bit ORDER_OPTION_D = 1'b0
) (
  input  wire logic                 clk,
  input  wire logic                 srst,
  input  wire logic                 sclk,
  input  wire logic                 csN,
  input  wire logic                 sdi,
  output logic                      sdo,
  output logic                      sdoOe,
  input  wire logic                 writeProtectN,
  output fsc_pkg::fsc_pins_type     pins,
  output logic [15:0]               statusWord,
  output logic [7:0]                configByte,
  output logic                      rangeProtectHit,
  input  wire logic                 rangeHitIn
);
  // ---------------- link domain (sclk) ----------------
  logic [4:0]  cnt_q;
  logic [7:0]  op_q;
  logic [15:0] dat_q;
  logic [7:0]  shOut_q;
  logic        drive_q;
  logic [15:0] statusSnap_q;
  logic [7:0]  configSnap_q;

  // Frame state resets on deselect: csN is the frame's own end
  always_ff @(posedge sclk or posedge csN) begin
    if (csN) begin
      cnt_q <= 5'h00;
      op_q  <= 8'h00;
      dat_q <= 16'h0000;
    end else begin
      if (cnt_q < 5'd8) begin
        op_q <= {op_q[6:0], sdi};
      end else begin
        dat_q <= {dat_q[14:0], sdi};
      end
      if (cnt_q != 5'h1f) begin
        cnt_q <= cnt_q + 5'd1;
      end
    end
  end

  always_ff @(negedge sclk or posedge csN) begin
    if (csN) begin
      shOut_q <= 8'h00;
      drive_q <= 1'b0;
    end else if (cnt_q == 5'd8) begin
      drive_q <= 1'b0;
      unique case (op_q)
        fsc_pkg::OP_STATUS_LO: begin
          shOut_q <= statusSnap_q[7:0];
          drive_q <= 1'b1;
        end
        fsc_pkg::OP_STATUS_HI: begin
          shOut_q <= statusSnap_q[15:8];
          drive_q <= 1'b1;
        end
        default: begin
          if (op_q == (ORDER_OPTION_D ? fsc_pkg::OP_CFG_READ_D : fsc_pkg::OP_CFG_READ_DEF)) begin
            shOut_q <= configSnap_q;
            drive_q <= 1'b1;
          end
        end
      endcase
    end else if (cnt_q > 5'd8) begin
      shOut_q <= {shOut_q[6:0], shOut_q[7]};
    end
  end

  assign sdo   = drive_q & shOut_q[7];
  assign sdoOe = drive_q & ~csN;

  // Frame capture at deselect; it stands until the next deselect, so the core
  // may read it once its own copy of csN has seen the rise
  fsc_pkg::fsc_frame_type frame_q;
  always_ff @(posedge csN) begin
    frame_q <= '{opcode: op_q, data: dat_q, bitCount: cnt_q};
  end

  // ---------------- core domain (clk) ----------------
  logic [2:0]  cs_q;
  logic        csStable_q;
  logic [2:0]  wp_q;
  logic        wpStable_q;
  logic        newFrame;
  logic [15:0] status_q;
  logic [7:0]  config_q;
  logic        wel_q;
  logic        volArm_q;
  logic        busy_q;
  logic [15:0] busyCnt_q;
  logic        eSus_q;
  logic        pSus_q;
  fsc_pkg::fsc_frame_type fr;
  logic [7:0]  op;
  logic        byteEnd;
  logic        wordEnd;
  logic        statusWrite;
  logic        modifying;
  logic        chipErase;
  logic        srWritable;
  logic [15:0] newStatus;

  // Chip select in the core domain; reset to the idle level so no false frame end follows reset
  always_ff @(posedge clk) begin
    if (srst) begin
      cs_q       <= 3'b111;
      csStable_q <= 1'b1;
    end else begin
      cs_q <= {cs_q[1:0], csN};
      if (cs_q[1] == cs_q[2]) begin
        csStable_q <= cs_q[2];
      end
    end
  end

  // Readout snapshot, frozen while the core sees a frame open, so the link never samples a moving word.
  // Limitation: the eight opcode clocks must outlast two core clocks.
  always_ff @(posedge clk) begin
    if (cs_q[1]) begin
      statusSnap_q <= statusWord;
      configSnap_q <= configByte;
    end
  end

  always_ff @(posedge clk) begin
    wp_q  <= {wp_q[1:0], writeProtectN};
    if (srst) begin
      wpStable_q <= 1'b1;
    end else if (wp_q[1] == wp_q[2]) begin
      wpStable_q <= wp_q[2];
    end
  end
  assign newFrame = cs_q[1] & cs_q[2] & ~csStable_q;
  assign fr       = frame_q;
  assign op       = fr.opcode;
  assign byteEnd  = fr.bitCount == 5'd16;
  assign wordEnd  = fr.bitCount == 5'd24;
  assign statusWrite = newFrame & ((op == fsc_pkg::OP_STATUS_WR_LO & (byteEnd | wordEnd))
                                   | (op == fsc_pkg::OP_STATUS_WR_HI & byteEnd));
  assign chipErase = op == fsc_pkg::OP_CHIP_ERASE_A | op == fsc_pkg::OP_CHIP_ERASE_B;
  assign modifying = newFrame & (op == fsc_pkg::OP_PAGE_PROG | op == fsc_pkg::OP_DUAL_PROG
                     | op == fsc_pkg::OP_QUAD_PROG | op == fsc_pkg::OP_PAGE_ERASE
                     | op == fsc_pkg::OP_SECTOR_ERASE | op == fsc_pkg::OP_HALF_BLK_ER
                     | op == fsc_pkg::OP_BLOCK_ERASE | op == fsc_pkg::OP_SECREG_ERASE
                     | op == fsc_pkg::OP_SECREG_PROG | chipErase);

  // Mode pair gating of status writes
  always_comb begin
    unique case (fsc_pkg::fsc_mode_type'({status_q[fsc_pkg::BIT_MODE_HI], status_q[fsc_pkg::BIT_MODE_LO]}))
      fsc_pkg::MODE_SOFT:       srWritable = 1'b1;
      fsc_pkg::MODE_HW:         srWritable = wpStable_q;
      fsc_pkg::MODE_POWER_LOCK: srWritable = 1'b0;
      fsc_pkg::MODE_OTP:        srWritable = 1'b0;
    endcase
  end

  // Write value merge: byte writes to the low byte clear complement, quad, mode high
  always_comb begin
    newStatus = status_q;
    if (op == fsc_pkg::OP_STATUS_WR_HI) begin
      newStatus[15:8] = fr.data[7:0];
    end else if (byteEnd) begin
      newStatus[7:0] = fr.data[7:0];
      newStatus[fsc_pkg::BIT_CMP]     = 1'b0;
      newStatus[fsc_pkg::BIT_QUAD]    = 1'b0;
      newStatus[fsc_pkg::BIT_MODE_HI] = 1'b0;
    end else begin
      newStatus = {fr.data[7:0], fr.data[15:8]};
    end
    newStatus = (newStatus & fsc_pkg::STATUS_WR_MASK) | (status_q & ~fsc_pkg::STATUS_WR_MASK);
    newStatus[13:11] = newStatus[13:11] | status_q[13:11];
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      status_q <= fsc_pkg::STATUS_RESET;
    end else if (statusWrite & (wel_q | volArm_q) & srWritable & ~busy_q) begin
      status_q <= newStatus;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      config_q <= fsc_pkg::CONFIG_RESET;
    end else if (newFrame & op == fsc_pkg::OP_CFG_WRITE & byteEnd & wel_q & ~busy_q) begin
      config_q <= fr.data[7:0] & fsc_pkg::CONFIG_WR_MASK;
    end
  end

  // Write enable latch
  always_ff @(posedge clk) begin
    if (srst) begin
      wel_q <= 1'b0;
    end else if (busy_q & busyCnt_q == 16'h0001) begin
      wel_q <= 1'b0;
    end else if (newFrame & op == fsc_pkg::OP_WRITE_DISABLE) begin
      wel_q <= 1'b0;
    end else if (newFrame & op == fsc_pkg::OP_SOFT_RESET) begin
      wel_q <= 1'b0;
    end else if (newFrame & op == fsc_pkg::OP_WRITE_ENABLE & ~busy_q) begin
      wel_q <= 1'b1;
    end
  end

  // Volatile arm: consumed by any following command
  always_ff @(posedge clk) begin
    if (srst) begin
      volArm_q <= 1'b0;
    end else if (newFrame) begin
      volArm_q <= op == fsc_pkg::OP_VOL_WRITE_ENABLE_CMD;
    end
  end

  // Busy timer for status write, program and erase
  always_ff @(posedge clk) begin
    if (srst) begin
      busy_q    <= 1'b0;
      busyCnt_q <= 16'h0000;
    end else if (busy_q) begin
      busyCnt_q <= busyCnt_q - 16'd1;
      busy_q    <= busyCnt_q != 16'h0001;
    end else if ((statusWrite & wel_q & srWritable)
                 | (modifying & wel_q & ~rangeHitIn
                    & (~chipErase | status_q[6:2] == fsc_pkg::RANGE_NONE))) begin
      busy_q    <= 1'b1;
      busyCnt_q <= 16'(BUSY_CYCLES);
    end
  end

  // Suspend flags
  always_ff @(posedge clk) begin
    if (srst) begin
      eSus_q <= 1'b0;
      pSus_q <= 1'b0;
    end else if (newFrame & (op == fsc_pkg::OP_RESUME_A | op == fsc_pkg::OP_RESUME_B)) begin
      eSus_q <= 1'b0;
      pSus_q <= 1'b0;
    end else if (newFrame & busy_q & (op == fsc_pkg::OP_SUSPEND_A | op == fsc_pkg::OP_SUSPEND_B)) begin
      eSus_q <= 1'b1;
      pSus_q <= 1'b0;
    end
  end

  always_comb begin
    statusWord = status_q;
    statusWord[fsc_pkg::BIT_BUSY] = busy_q;
    statusWord[fsc_pkg::BIT_WEL]  = wel_q;
    statusWord[fsc_pkg::BIT_PSUS] = pSus_q;
    statusWord[fsc_pkg::BIT_ESUS] = eSus_q;
  end
  assign configByte = config_q & fsc_pkg::CONFIG_WR_MASK;

  assign pins.quadLines  = status_q[fsc_pkg::BIT_QUAD];
  assign pins.pinIsPause = ~status_q[fsc_pkg::BIT_QUAD] & ~config_q[fsc_pkg::CFG_PAUSE_RST];
  assign pins.pinIsReset = ~status_q[fsc_pkg::BIT_QUAD] & config_q[fsc_pkg::CFG_PAUSE_RST];
  assign pins.widePage   = config_q[fsc_pkg::CFG_WIDE_PAGE];
  assign pins.lockScheme = config_q[fsc_pkg::CFG_LOCK_SCH];
  assign pins.drive      = config_q[6:5];
  assign rangeProtectHit = ~config_q[fsc_pkg::CFG_LOCK_SCH] & (status_q[6:2] != fsc_pkg::RANGE_NONE);
endmodule : fsc_regs
`default_nettype wire

// ### dv/fsc_regs_properties.sv
// Concurrent checks on the status and configuration register block ports
`timescale 1ns/10ps
`default_nettype none
module fsc_regs_properties #(
  parameter int BUSY_CYCLES = 4
) (
  input wire logic                  clk,
  input wire logic                  srst,
  input wire logic                  sclk,
  input wire logic                  csN,
  input wire logic                  sdi,
  input wire logic                  sdo,
  input wire logic                  sdoOe,
  input wire logic                  writeProtectN,
  input wire fsc_pkg::fsc_pins_type pins,
  input wire logic [15:0]           statusWord,
  input wire logic [7:0]            configByte,
  input wire logic                  rangeProtectHit,
  input wire logic                  rangeHitIn
);
  logic [15:0] busyCnt_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  always_ff @(posedge clk) begin
    if (srst) busyCnt_q <= 16'h0000;
    else busyCnt_q <= statusWord[0] ? busyCnt_q + 16'h0001 : 16'h0000;
  end
  chk_sdo_release: assert property (csN [*3] |-> !sdoOe)
    else $error("serial output still driven after deselect");
  chk_reset_values: assert property ($fell(srst) |-> statusWord == fsc_pkg::STATUS_RESET
    && configByte == fsc_pkg::CONFIG_RESET)
    else $error("wrong register values after reset");
  chk_busy_bound: assert property (busyCnt_q <= BUSY_CYCLES)
    else $error("busy held too long");
  chk_latch_after_busy: assert property ($fell(statusWord[0]) |-> !statusWord[1])
    else $error("latch still set after operation end");
  chk_reserved_zero: assert property (configByte[3] == 1'b0 && configByte[1:0] == 2'b00)
    else $error("reserved config bits not zero");
  chk_quad_lines: assert property ($stable(statusWord) |-> pins.quadLines == statusWord[9])
    else $error("quad line steering wrong");
  chk_pin_steer: assert property ($stable(statusWord) && $stable(configByte) |->
    pins.pinIsPause == (!statusWord[9] && !configByte[7]) && pins.pinIsReset == (!statusWord[9] && configByte[7])
    && pins.widePage == configByte[4] && pins.drive == configByte[6:5])
    else $error("pin function steering wrong");
  chk_range_hit: assert property ($stable(statusWord) && $stable(configByte) |->
    rangeProtectHit == (statusWord[6:2] != 5'h00 && !configByte[2]))
    else $error("range protect flag wrong");
  chk_locks_sticky: assert property ((($past(statusWord[13:11]) & ~statusWord[13:11]) == 3'h0))
    else $error("security lock bit cleared");
endmodule : fsc_regs_properties
bind fsc_regs fsc_regs_properties #(.BUSY_CYCLES(BUSY_CYCLES)) i_props (.clk(clk), .srst(srst), .sclk(sclk),
  .csN(csN), .sdi(sdi), .sdo(sdo), .sdoOe(sdoOe), .writeProtectN(writeProtectN), .pins(pins),
  .statusWord(statusWord), .configByte(configByte), .rangeProtectHit(rangeProtectHit), .rangeHitIn(rangeHitIn));
`default_nettype wire

// ### dv/fsc_host_model.sv
// Host controller model driving the serial command link in mode 0
`timescale 1ns/10ps
`default_nettype none
module fsc_host_model (
  input  wire logic clk,
  output logic      sclk,
  output logic      csN,
  output logic      sdi,
  input  wire logic sdo,
  input  wire logic sdoOe
);
  logic lastSdo;
  logic lineSdo;
  // A released line must not look like valid data
  always @(negedge sdoOe) lastSdo = ~sdo;
  assign lineSdo = sdoOe ? sdo : lastSdo;
  initial begin
    sclk = 1'b0;
    csN = 1'b1;
    sdi = 1'b0;
    lastSdo = 1'b0;
  end
  // Link clock runs only inside a frame
  task automatic frame(input logic [7:0] op, input logic [15:0] dat, input int nBits, output logic [7:0] rd);
    logic [23:0] sh;
    sh = {op, dat};
    rd = 8'h00;
    @(posedge clk);
    #3 csN = 1'b0;
    for (int i = 0; i < 8 + nBits; i++) begin
      sdi = sh[23 - i];
      #7.5 sclk = 1'b1;
      if (i >= 8) rd = {rd[6:0], lineSdo};
      #7.5 sclk = 1'b0;
    end
    #7.5 csN = 1'b1;
    sdi = ~sdi;
    repeat (5) @(posedge clk);
  endtask : frame
  task automatic wait_idle(output logic [7:0] st);
    for (int k = 0; k < 60; k++) begin
      frame(fsc_pkg::OP_STATUS_LO, 16'h0000, 8, st);
      if (st[0] === 1'b0) break;
    end
  endtask : wait_idle
endmodule : fsc_host_model
`default_nettype wire

// ### dv/fsc_regs_tb.sv
// Self-checking bench for the status and configuration register block
`timescale 1ns/10ps
`default_nettype none
module fsc_regs_tb;
  logic                  clk = 1'b0;
  logic                  srst = 1'b1;
  logic                  writeProtectN = 1'b1;
  logic                  rangeHitIn = 1'b0;
  logic                  sclk;
  logic                  csN;
  logic                  sdi;
  logic                  sdo;
  logic                  sdoOe;
  fsc_pkg::fsc_pins_type pins;
  logic [15:0]           statusWord;
  logic [7:0]            configByte;
  logic                  rangeProtectHit;
  int                    n_errors = 0;
  int                    n_checks = 0;
  int                    cycles = 0;
  logic [7:0]            rd;
  always #20 clk = ~clk;
  fsc_regs #(.BUSY_CYCLES(20), .ORDER_OPTION_D(1'b0)) i_dut (.clk(clk), .srst(srst), .sclk(sclk), .csN(csN),
    .sdi(sdi), .sdo(sdo), .sdoOe(sdoOe), .writeProtectN(writeProtectN), .pins(pins), .statusWord(statusWord),
    .configByte(configByte), .rangeProtectHit(rangeProtectHit), .rangeHitIn(rangeHitIn));
  fsc_host_model i_host (.clk(clk), .sclk(sclk), .csN(csN), .sdi(sdi), .sdo(sdo), .sdoOe(sdoOe));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test;
    $display("Checks %0d, errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  task automatic rd8(input logic [7:0] op);
    i_host.frame(op, 16'h0000, 8, rd);
  endtask : rd8
  task automatic cmd(input logic [7:0] op, input logic [15:0] dat, input int n);
    i_host.frame(op, dat, n, rd);
  endtask : cmd
  task automatic test_reset;
    rd8(fsc_pkg::OP_STATUS_LO);
    check(rd, 16'h0000);
    rd8(fsc_pkg::OP_STATUS_HI);
    check(rd, 16'h0000);
    rd8(fsc_pkg::OP_CFG_READ_DEF);
    check(rd, 16'h0040);
    check(configByte, 16'h0040);
  endtask : test_reset
  task automatic test_latch;
    cmd(fsc_pkg::OP_VOL_WRITE_ENABLE_CMD, 16'h0000, 0);
    rd8(fsc_pkg::OP_STATUS_LO);
    check(rd, 16'h0000);
    cmd(fsc_pkg::OP_STATUS_WR_LO, 16'h1c02, 16);
    check(statusWord, 16'h0000);
    cmd(fsc_pkg::OP_WRITE_ENABLE, 16'h0000, 0);
    rd8(fsc_pkg::OP_STATUS_LO);
    check(rd, 16'h0002);
    cmd(fsc_pkg::OP_WRITE_DISABLE, 16'h0000, 0);
    rd8(fsc_pkg::OP_STATUS_LO);
    check(rd, 16'h0000);
    cmd(fsc_pkg::OP_VOL_WRITE_ENABLE_CMD, 16'h0000, 0);
    cmd(fsc_pkg::OP_STATUS_WR_LO, 16'h0400, 8);
    check(statusWord, 16'h0004);
    cmd(fsc_pkg::OP_VOL_WRITE_ENABLE_CMD, 16'h0000, 0);
    cmd(fsc_pkg::OP_STATUS_WR_LO, 16'h0000, 8);
    check(statusWord, 16'h0000);
  endtask : test_latch
  task automatic test_write;
    cmd(fsc_pkg::OP_WRITE_ENABLE, 16'h0000, 0);
    cmd(fsc_pkg::OP_STATUS_WR_LO, 16'h1c02, 16); // quad pins are not tied in this bench
    rd8(fsc_pkg::OP_STATUS_LO);
    check(rd[0], 16'h0001);
    i_host.wait_idle(rd);
    check(rd, 16'h001c);
    rd8(fsc_pkg::OP_STATUS_HI);
    check(rd, 16'h0002);
    check(pins.quadLines, 16'h0001);
    check(rangeProtectHit, 16'h0001);
  endtask : test_write
  task automatic test_locks;
    cmd(fsc_pkg::OP_WRITE_ENABLE, 16'h0000, 0);
    cmd(fsc_pkg::OP_CHIP_ERASE_A, 16'h0000, 0);
    check(statusWord[1:0], 16'h0002);
    cmd(fsc_pkg::OP_STATUS_WR_HI, 16'h0a00, 8);
    i_host.wait_idle(rd);
    rd8(fsc_pkg::OP_STATUS_HI);
    check(rd, 16'h000a);
    cmd(fsc_pkg::OP_WRITE_ENABLE, 16'h0000, 0);
    cmd(fsc_pkg::OP_STATUS_WR_HI, 16'h0200, 8);
    i_host.wait_idle(rd);
    rd8(fsc_pkg::OP_STATUS_HI);
    check(rd, 16'h000a);
  endtask : test_locks
  task automatic test_config;
    cmd(fsc_pkg::OP_WRITE_ENABLE, 16'h0000, 0);
    cmd(fsc_pkg::OP_CFG_WRITE, 16'hff00, 8);
    check(configByte, 16'h00f4);
    check(pins.widePage, 16'h0001);
    check(pins.lockScheme, 16'h0001);
    check(rangeProtectHit, 16'h0000);
    check(pins.pinIsReset, 16'h0000);
    check(pins.drive, 16'h0003);
    rd8(fsc_pkg::OP_CFG_READ_DEF);
    check(rd, 16'h00f4);
    cmd(fsc_pkg::OP_CFG_WRITE, 16'h4000, 8);
    check(configByte, 16'h0040);
    check(rangeProtectHit, 16'h0001);
    cmd(fsc_pkg::OP_WRITE_DISABLE, 16'h0000, 0);
  endtask : test_config
  task automatic test_suspend;
    logic [15:0] pairs[2];
    pairs[0] = {fsc_pkg::OP_SUSPEND_A, fsc_pkg::OP_RESUME_A};
    pairs[1] = {fsc_pkg::OP_SUSPEND_B, fsc_pkg::OP_RESUME_B};
    for (int p = 0; p < 2; p++) begin
      cmd(fsc_pkg::OP_WRITE_ENABLE, 16'h0000, 0);
      cmd(fsc_pkg::OP_SECTOR_ERASE, 16'h0000, 0);
      cmd(pairs[p][15:8], 16'h0000, 0);
      rd8(fsc_pkg::OP_STATUS_HI);
      check(rd, 16'h008a);
      cmd(pairs[p][7:0], 16'h0000, 0);
      rd8(fsc_pkg::OP_STATUS_HI);
      check(rd, 16'h000a);
      i_host.wait_idle(rd);
    end
  endtask : test_suspend
  task automatic test_protect;
    cmd(fsc_pkg::OP_WRITE_ENABLE, 16'h0000, 0);
    cmd(fsc_pkg::OP_STATUS_WR_LO, 16'h8002, 16);
    i_host.wait_idle(rd);
    check(rd, 16'h0080);
    @(posedge clk);
    writeProtectN <= 1'b0;
    repeat (5) @(posedge clk);
    cmd(fsc_pkg::OP_WRITE_ENABLE, 16'h0000, 0);
    cmd(fsc_pkg::OP_STATUS_WR_LO, 16'h0002, 16);
    i_host.wait_idle(rd);
    check(rd & 8'hfc, 16'h0080);
  endtask : test_protect
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      stop_test();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    test_reset();
    test_latch();
    test_write();
    test_locks();
    test_config();
    test_suspend();
    test_protect();
    stop_test();
  end
endmodule : fsc_regs_tb
`default_nettype wire
